// file: core/smc_pkg.sv
`default_nettype none

package smc_pkg;

   // ----------------------------------------
   // register map (bit 8 is the upper bank)
   // ----------------------------------------
   localparam logic [8:0] ADDR_SUPPLY_MONITOR_CONFIG    = 9'h1E3;
   localparam logic [8:0] ADDR_SUPPLY_COMPARATOR_STATE  = 9'h1E4;
   localparam logic [8:0] ADDR_MONITOR_SLEEP_DUTY       = 9'h1EB;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int         RANGE_LSB      = 4;
   localparam int         TRIP_SEL_LSB   = 0;
   localparam int         DUTY_LSB       = 6;
   localparam int         LOW_FLAG_BIT   = 1;
   localparam int         PRECISE_BIT    = 0;
   localparam logic [1:0] RANGE_RESET    = 2'h0;
   localparam logic [2:0] TRIP_RESET     = 3'h0;
   localparam logic [1:0] DUTY_RESET     = 2'h0;
   localparam logic [7:0] READ_ZERO      = 8'h00;

   // ----------------------------------------
   // encodings
   // ----------------------------------------
   localparam logic [1:0] RANGE_2V7      = 2'h0;
   localparam logic [1:0] RANGE_3V       = 2'h1;
   localparam logic [1:0] RANGE_5V       = 2'h2;
   localparam logic [1:0] RANGE_REPORT   = 2'h3;
   localparam int         TRIP_VALID_BIT = 2;

   // on-time ratio: one period of every N slow-clock periods, each constant holds N - 1
   localparam logic [8:0] DUTY_N_00      = 9'h07F;
   localparam logic [8:0] DUTY_N_01      = 9'h1FF;
   localparam logic [8:0] DUTY_N_10      = 9'h01F;
   localparam logic [8:0] DUTY_N_11      = 9'h007;
   localparam logic [8:0] DUTY_CNT_ZERO  = 9'h000;
   localparam logic [8:0] DUTY_CNT_ONE   = 9'h001;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {SMC_AWAKE, SMC_ASLEEP, SMC_WAKING} smc_phase_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [8:0] addr;
      logic [7:0] wdata;
   } smc_io_req_s;

   typedef struct packed {
      logic [1:0] sync_precise;
      logic [1:0] sync_low;
      logic [1:0] sync_slow_clk;
      logic [1:0] sync_pd;
      logic       slow_clk_d;
      logic       pd_d;
      logic [1:0] reset_trip_range;
      logic [2:0] low_supply_trip_select;
      logic [1:0] sleep_duty;
      logic       precise_reset_comparator;
      logic       low_supply_flag;
      smc_phase_e phase;
      logic [8:0] duty_cnt;
      logic       monitor_on;
      logic       reset_request;
      logic [1:0] range_to_analog;
      logic [7:0] rdata;
   } smc_state_s;

endpackage : smc_pkg

`default_nettype wire

// file: core/smc_supply_monitor_control.sv
// Function
// - reset trip range codes 00, 01, 10 pick the 2.7 V, 3 V and 5 V ranges.
// - range code 11 never resets but still reports the comparator, trip set to the 3 V range.
// - status bit 1 is one while the low-voltage comparator is tripped and the trip select is not a reserved code.
// - the three-bit trip select sets the low-voltage point; codes 000 to 011 are reserved.
// - status bit 0 is one while the precision comparator shows supply below the trip point.
// - the status register is read-only, shows live state while awake (duty-window samples in sleep, held while waking), and bits 7:2 read zero.
// - duty field bits 7:6 give on-time 1/128, 1/512, 1/32, 1/8 of slow-clock periods.
// - config resets to zero, bits 7:6 and 3 reserved, range in 5:4, select in 2:0.
// - during sleep the monitor runs at the reduced duty, trading latency for power.
// - one slow-clock rising edge after power-down release the comparators are sampled.
`timescale 1ns/1ps
`default_nettype none

module smc_supply_monitor_control
(
   // clock, reset, enable
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire logic                 ce,
   // io register port, bit 8 of addr is the upper bank select
   input  wire smc_pkg::smc_io_req_s io_req,
   output logic [7:0]                io_rdata,
   // analog and sleep-logic pins, asynchronous
   input  wire logic                 precise_cmp,
   input  wire logic                 low_cmp,
   input  wire logic                 slow_clk,
   input  wire logic                 power_down,
   // controls to the analog monitor and the chip
   output logic [1:0]                range_sel,
   output logic [2:0]                trip_sel,
   output logic                      monitor_enable,
   output logic                      reset_request
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // last count of the duty cycle for a given field value
   function automatic logic [8:0] duty_last(input logic [1:0] code);
      unique case (code)
         2'h0: duty_last = smc_pkg::DUTY_N_00;
         2'h1: duty_last = smc_pkg::DUTY_N_01;
         2'h2: duty_last = smc_pkg::DUTY_N_10;
         2'h3: duty_last = smc_pkg::DUTY_N_11;
      endcase
   endfunction : duty_last

   function automatic logic hit(input smc_pkg::smc_io_req_s r, input logic [8:0] a);
      hit = (r.addr == a);
   endfunction : hit

   smc_pkg::smc_state_s s;
   smc_pkg::smc_state_s next_s;
   logic                slow_rise;
   logic                pd_fall;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      next_s = s;
      slow_rise = s.sync_slow_clk[1] & ~s.slow_clk_d;
      pd_fall = ~s.sync_pd[1] & s.pd_d;

      // two-flop synchronisers; only stage 1 is read by logic
      next_s.sync_precise  = {s.sync_precise[0], precise_cmp};
      next_s.sync_low      = {s.sync_low[0], low_cmp};
      next_s.sync_slow_clk = {s.sync_slow_clk[0], slow_clk};
      next_s.sync_pd       = {s.sync_pd[0], power_down};
      next_s.slow_clk_d    = s.sync_slow_clk[1];
      next_s.pd_d          = s.sync_pd[1];

      // register writes; only documented fields store, reserved bits stay zero
      if (io_req.wr && hit(io_req, smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG))
      begin
         next_s.reset_trip_range       = io_req.wdata[smc_pkg::RANGE_LSB +: 2];
         next_s.low_supply_trip_select = io_req.wdata[smc_pkg::TRIP_SEL_LSB +: 3];
      end
      if (io_req.wr && hit(io_req, smc_pkg::ADDR_MONITOR_SLEEP_DUTY))
         next_s.sleep_duty = io_req.wdata[smc_pkg::DUTY_LSB +: 2];

      // analog range: report mode trips at the 3 V range
      next_s.range_to_analog = (s.reset_trip_range == smc_pkg::RANGE_REPORT)
                               ? smc_pkg::RANGE_3V : s.reset_trip_range;

      // phase of the monitor around sleep
      unique case (s.phase)
         smc_pkg::SMC_AWAKE:
         begin
            next_s.monitor_on = 1'h1;
            next_s.duty_cnt   = smc_pkg::DUTY_CNT_ZERO;
            if (s.sync_pd[1])
               next_s.phase = smc_pkg::SMC_ASLEEP;
         end
         smc_pkg::SMC_ASLEEP:
         begin
            // one on-period per duty frame, longer frames save power but add latency
            if (slow_rise)
            begin
               next_s.duty_cnt = (s.duty_cnt >= duty_last(s.sleep_duty))
                                 ? smc_pkg::DUTY_CNT_ZERO
                                 : s.duty_cnt + smc_pkg::DUTY_CNT_ONE;
               next_s.monitor_on = (next_s.duty_cnt == smc_pkg::DUTY_CNT_ZERO);
            end
            if (pd_fall)
            begin
               next_s.phase      = smc_pkg::SMC_WAKING;
               next_s.monitor_on = 1'h1;
            end
         end
         smc_pkg::SMC_WAKING:
         begin
            // outputs settle until the next slow-clock rising edge
            if (slow_rise)
               next_s.phase = smc_pkg::SMC_AWAKE;
         end
      endcase

      // comparator capture: live when awake, duty window in sleep, settled on wake
      if ((s.phase == smc_pkg::SMC_AWAKE)
          || (s.phase == smc_pkg::SMC_ASLEEP && s.monitor_on && slow_rise)
          || (s.phase == smc_pkg::SMC_WAKING && slow_rise))
      begin
         next_s.precise_reset_comparator = s.sync_precise[1];
         // reserved select codes leave the low-supply flag clear
         next_s.low_supply_flag = s.sync_low[1]
                                  & s.low_supply_trip_select[smc_pkg::TRIP_VALID_BIT];
      end

      // reset request unless in report-only mode
      next_s.reset_request = s.precise_reset_comparator
                             & (s.reset_trip_range != smc_pkg::RANGE_REPORT);

      // read data; unmapped addresses and no read give zero
      next_s.rdata = smc_pkg::READ_ZERO;
      if (io_req.rd)
      begin
         if (hit(io_req, smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG))
         begin
            next_s.rdata[smc_pkg::RANGE_LSB +: 2]    = s.reset_trip_range;
            next_s.rdata[smc_pkg::TRIP_SEL_LSB +: 3] = s.low_supply_trip_select;
         end
         else if (hit(io_req, smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE))
         begin
            next_s.rdata[smc_pkg::LOW_FLAG_BIT] = s.low_supply_flag;
            next_s.rdata[smc_pkg::PRECISE_BIT]  = s.precise_reset_comparator;
         end
         else if (hit(io_req, smc_pkg::ADDR_MONITOR_SLEEP_DUTY))
            next_s.rdata[smc_pkg::DUTY_LSB +: 2] = s.sleep_duty;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // clear on reset except monitor_on, which resets to one; ce low freezes everything
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         s                        <= '0;
         s.reset_trip_range       <= smc_pkg::RANGE_RESET;
         s.low_supply_trip_select <= smc_pkg::TRIP_RESET;
         s.sleep_duty             <= smc_pkg::DUTY_RESET;
         s.phase                  <= smc_pkg::SMC_AWAKE;
         s.monitor_on             <= 1'h1;
      end
      else if (ce)
         s <= next_s;
   end

   assign io_rdata       = s.rdata;
   assign range_sel      = s.range_to_analog;
   assign trip_sel       = s.low_supply_trip_select;
   assign monitor_enable = s.monitor_on;
   assign reset_request  = s.reset_request;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_range_report_map: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && s.reset_trip_range == smc_pkg::RANGE_REPORT |=> range_sel == smc_pkg::RANGE_3V)
      else $error("report mode does not trip at 3 V range");

   a_range_passthru: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && s.reset_trip_range != smc_pkg::RANGE_REPORT |=> range_sel == $past(s.reset_trip_range))
      else $error("range select does not follow field");

   a_reset_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && s.precise_reset_comparator && s.reset_trip_range != smc_pkg::RANGE_REPORT |=> reset_request)
      else $error("reset request missing");

   a_no_reset_report: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && s.reset_trip_range == smc_pkg::RANGE_REPORT |=> !reset_request)
      else $error("reset in report mode");

   a_status_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && io_req.rd && hit(io_req, smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE)
      |=> io_rdata == {6'h00, $past(s.low_supply_flag), $past(s.precise_reset_comparator)})
      else $error("status read wrong");

   a_low_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
      !s.low_supply_trip_select[smc_pkg::TRIP_VALID_BIT] && $past(ce)
      && !$past(s.low_supply_trip_select[smc_pkg::TRIP_VALID_BIT]) |-> !s.low_supply_flag)
      else $error("low flag set with reserved select");

   a_awake_live: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && s.phase == smc_pkg::SMC_AWAKE |=> s.precise_reset_comparator == $past(s.sync_precise[1]))
      else $error("precise status not live");

   a_wake_sample: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && s.phase == smc_pkg::SMC_WAKING && slow_rise
      |=> s.phase == smc_pkg::SMC_AWAKE && s.precise_reset_comparator == $past(s.sync_precise[1]))
      else $error("wake sample missed");

   a_wake_freeze: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && s.phase == smc_pkg::SMC_WAKING && !slow_rise |=> $stable(s.precise_reset_comparator))
      else $error("status moved before settle edge");

   a_duty_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && s.phase == smc_pkg::SMC_ASLEEP && slow_rise && !pd_fall
      && s.duty_cnt >= duty_last(s.sleep_duty) |=> s.duty_cnt == smc_pkg::DUTY_CNT_ZERO && monitor_enable)
      else $error("duty frame did not wrap");

   a_config_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && io_req.wr && hit(io_req, smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG)
      |=> s.reset_trip_range == $past(io_req.wdata[smc_pkg::RANGE_LSB +: 2])
          && trip_sel == $past(io_req.wdata[smc_pkg::TRIP_SEL_LSB +: 3]))
      else $error("config write lost");

endmodule : smc_supply_monitor_control

`default_nettype wire

// file: tb/smc_supply_monitor_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module smc_supply_monitor_control_test;

   // ----------------------------------------
   // clocks, stimulus and observed outputs
   // ----------------------------------------
   logic                 sys_clk        = 1'h0;
   logic                 resetn         = 1'h0;
   logic                 ce             = 1'h1;
   smc_pkg::smc_io_req_s req            = '0;
   logic                 precise_cmp_in = 1'h0;
   logic                 low_cmp_in     = 1'h0;
   logic                 slow_clk       = 1'h0;
   logic                 power_down     = 1'h0;
   logic [7:0]           io_rdata;
   logic [1:0]           range_sel;
   logic [2:0]           trip_sel;
   logic                 monitor_enable;
   logic                 reset_request;
   int                   n_errors       = 0;
   int                   cmp_count      = 0;
   int                   hi;
   int                   k;
   int                   nper [4]       = '{128, 512, 32, 8};

   // 125 MHz system clock
   always #4 sys_clk = ~sys_clk;

   // scaled-down slow oscillator, 40 system cycles a period, keeps the run short
   always
   begin
      repeat (20) @(posedge sys_clk);
      #1 slow_clk = ~slow_clk;
   end

   smc_supply_monitor_control dut
   (
      .sys_clk        (sys_clk),
      .resetn         (resetn),
      .ce             (ce),
      .io_req         (req),
      .io_rdata       (io_rdata),
      .precise_cmp    (precise_cmp_in),
      .low_cmp        (low_cmp_in),
      .slow_clk       (slow_clk),
      .power_down     (power_down),
      .range_sel      (range_sel),
      .trip_sel       (trip_sel),
      .monitor_enable (monitor_enable),
      .reset_request  (reset_request)
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one-cycle write strobe, released one step after the taking edge
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      req.wr    = 1'h1;
      req.addr  = a;
      req.wdata = d;
      @(posedge sys_clk);
      #1;
      req.wr    = 1'h0;
   endtask : wr

   // read data stands only in the cycle after the taking edge
   task automatic rdchk(input logic [8:0] a, input logic [7:0] exp, input string what);
      @(posedge sys_clk);
      #1;
      req.rd   = 1'h1;
      req.addr = a;
      @(posedge sys_clk);
      #1;
      req.rd   = 1'h0;
      chk(what, io_rdata, exp);
   endtask : rdchk

   task automatic settle();
      repeat (6) @(posedge sys_clk);
      // step off the edge so outputs are settled and stimulus lands late
      #1;
   endtask : settle

   task automatic tally_and_finish();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge sys_clk);
      #1 resetn = 1'h1;
      // reset values and field masks
      rdchk(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, 8'h00, "config reset");
      rdchk(smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE, 8'h00, "status reset");
      rdchk(smc_pkg::ADDR_MONITOR_SLEEP_DUTY, 8'h00, "duty reset");
      chk("monitor on", {7'h00, monitor_enable}, 8'h01);
      wr(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, 8'hFF);
      rdchk(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, 8'h37, "config mask");
      chk("trip select", {5'h00, trip_sel}, 8'h07);
      wr(smc_pkg::ADDR_MONITOR_SLEEP_DUTY, 8'hFF);
      rdchk(smc_pkg::ADDR_MONITOR_SLEEP_DUTY, 8'hC0, "duty mask");
      wr(smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE, 8'hFF);
      rdchk(smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE, 8'h00, "status ro");
      // lower bank must not alias the monitor registers
      wr(9'h0E3, 8'h00);
      rdchk(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, 8'h37, "no bank write");
      rdchk(9'h0E3, 8'h00, "no bank read");
      rdchk(9'h1E5, 8'h00, "unmapped read");
      // clock enable low freezes the register port
      @(posedge sys_clk);
      #1 ce = 1'h0;
      wr(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, 8'h00);
      ce = 1'h1;
      rdchk(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, 8'h37, "frozen");
      // every range code with both comparators tripped
      precise_cmp_in = 1'h1;
      low_cmp_in     = 1'h1;
      for (int i = 0; i < 4; i++)
      begin
         wr(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, {2'h0, 2'(i), 4'h4});
         settle();
         chk("range", {6'h00, range_sel}, (i == 3) ? 8'h01 : 8'(i));
         chk("reset req", {7'h00, reset_request}, (i == 3) ? 8'h00 : 8'h01);
         rdchk(smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE, 8'h03, "status both");
      end
      // reserved trip select hides the low-voltage flag
      wr(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, 8'h03);
      settle();
      rdchk(smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE, 8'h01, "reserved trip");
      precise_cmp_in = 1'h0;
      low_cmp_in     = 1'h0;
      settle();
      rdchk(smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE, 8'h00, "status clear");
      chk("reset released", {7'h00, reset_request}, 8'h00);
      // sleep duty for every code, one on period per frame of nper slow periods
      // firmware runs the cpu fast around these tests, so the 5 V range
      wr(smc_pkg::ADDR_SUPPLY_MONITOR_CONFIG, 8'h24);
      for (int i = 0; i < 4; i++)
      begin
         wr(smc_pkg::ADDR_MONITOR_SLEEP_DUTY, {2'(i), 6'h00});
         power_down = 1'h1;
         // look a step after each edge, never in the edge's own time step
         for (k = 0; k < 2000 && monitor_enable !== 1'h0; k++)
         begin
            @(posedge sys_clk);
            #1;
         end
         if (k == 2000)
         begin
            n_errors++;
            tally_and_finish();
         end
         repeat (2) @(negedge slow_clk);
         hi = 0;
         repeat (2 * nper[i])
         begin
            @(negedge slow_clk);
            hi += int'(monitor_enable === 1'h1);
         end
         chk("on periods", 8'(hi), 8'h02);
         // supply drops while asleep, must show once awake
         precise_cmp_in = 1'h1;
         @(negedge slow_clk);
         power_down = 1'h0;
         repeat (3) @(negedge slow_clk);
         settle();
         rdchk(smc_pkg::ADDR_SUPPLY_COMPARATOR_STATE, 8'h01, "wake sample");
         chk("awake on", {7'h00, monitor_enable}, 8'h01);
         chk("wake reset", {7'h00, reset_request}, 8'h01);
         chk("fast range", {6'h00, range_sel}, 8'h02);
         precise_cmp_in = 1'h0;
         settle();
      end
      tally_and_finish();
   end

endmodule : smc_supply_monitor_control_test

`default_nettype wire
